//--- logic/jxs_pkg.sv
// Purpose: Shared constants and types for the jump, increment, OR and shift execute unit
// Assumes: One core clock; the file register port answers within the issue cycle
// Notes: Function list below is kept with the constants
//
// Function
// - The long jump loads its 11-bit operand into program counter bits 10 to 0.
// - The long jump fills program counter bits 14 to 11 from latch bits 6 to 3.
// - The long jump takes two cycles and leaves every flag as it was.
// - A 7-bit file address is used; destination 0 writes the accumulator, 1 the file.
// - Both increments add one to the file value and deliver it to the destination.
// - Increment-and-skip squashes the next instruction on a zero result, no flags.
// - OR with literal ORs the accumulator with 8 bits, writes it back, sets zero.
// - OR with file ORs accumulator and file into the destination, sets zero.
// - The left shift moves file bit 7 into the carry flag.
// - The left shift puts bits 6 to 0 into 7 to 1, a zero into bit 0, sets C and Z.

package jxs_pkg;

  // Widths
  localparam int PC_W = 15;
  localparam int JUMP_K_W = 11;
  localparam int LATCH_W = 7;
  localparam int FADDR_W = 7;
  localparam int DATA_W = 8;

  // Latch field feeding the upper program counter bits
  localparam int LATCH_HI = 6;
  localparam int LATCH_LO = 3;

  // Shift field positions
  localparam int SHIFT_OUT_BIT = 7;

  // Cycle counts
  localparam int JUMP_CYCLES = 2;
  localparam int SKIP_CYCLES = 2;
  localparam int PLAIN_CYCLES = 1;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic FLAG_RST = 1'b0;

  // Destination select encoding
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Operations handled here
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_LONG_JUMP = 3'h1,
    OP_INCR_SKIP_IF_ZERO = 3'h2,
    OP_INCR_FILE = 3'h3,
    OP_OR_LITERAL_INTO_ACC = 3'h4,
    OP_OR_ACC_WITH_FILE = 3'h5,
    OP_SHIFT_LEFT_FILE = 3'h6
  } jxs_op_t;

  // Sequencer states, Gray coded
  typedef enum logic {
    ST_RUN = 1'b0,
    ST_BUBBLE = 1'b1
  } jxs_state_t;

  // Decoded instruction
  typedef struct packed {
    jxs_op_t op;
    logic [JUMP_K_W-1:0] k_jump;
    logic [DATA_W-1:0] k_lit;
    logic [FADDR_W-1:0] faddr;
    logic dest;
  } jxs_instr_t;

  // File register write port
  typedef struct packed {
    logic en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } jxs_fwr_t;

endpackage

//--- logic/jxs_exec.sv
// Purpose: Execute long jump, increments, OR and left shift for an 8-bit core
// Assumes: file_rdata is the addressed file value, valid in the issue cycle
// Notes: Results, flags and the jump target appear one cycle after issue

`timescale 1ns/1ps

module jxs_exec (
  input wire logic mclk,
  input wire logic srst,
  input wire logic instr_valid,
  input wire jxs_pkg::jxs_instr_t instr,
  output logic instr_ready,
  input wire logic [jxs_pkg::DATA_W-1:0] file_rdata,
  input wire logic [jxs_pkg::LATCH_W-1:0] pc_high_latch,
  output jxs_pkg::jxs_fwr_t fwr,
  output logic [jxs_pkg::DATA_W-1:0] acc,
  output logic carry,
  output logic zero,
  output logic pc_load,
  output logic [jxs_pkg::PC_W-1:0] pc_value,
  output logic skip_taken
);
  import jxs_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  jxs_state_t state_r, state_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt, res_r, res_nxt;
  logic carry_r, carry_nxt, zero_r, zero_nxt;
  logic pc_load_r, skip_r;
  logic [PC_W-1:0] pc_r, pc_nxt;
  jxs_fwr_t fwr_r, fwr_nxt;

  wire fire = instr_valid && instr_ready;
  wire is_jump = instr.op == OP_LONG_JUMP;
  wire is_incsz = instr.op == OP_INCR_SKIP_IF_ZERO;
  wire is_inc = instr.op == OP_INCR_FILE;
  wire is_orl = instr.op == OP_OR_LITERAL_INTO_ACC;
  wire is_orf = instr.op == OP_OR_ACC_WITH_FILE;
  wire is_shl = instr.op == OP_SHIFT_LEFT_FILE;
  wire to_dest = is_incsz || is_inc || is_orf || is_shl;
  wire sets_zero = is_inc || is_orl || is_orf || is_shl;

  // Arithmetic and logic results
  wire [DATA_W-1:0] inc_val = file_rdata + 8'h01;
  wire [DATA_W-1:0] orl_val = acc_r | instr.k_lit;
  wire [DATA_W-1:0] orf_val = acc_r | file_rdata;
  wire [DATA_W-1:0] shl_val = {file_rdata[DATA_W-2:0], 1'b0};
  wire [DATA_W-1:0] result = (is_incsz || is_inc) ? inc_val :
                             is_orl ? orl_val :
                             is_orf ? orf_val :
                             is_shl ? shl_val : 8'h00;
  wire res_is_zero = result == 8'h00;
  wire skip_now = is_incsz && res_is_zero;
  wire [PC_W-1:0] jump_tgt = {pc_high_latch[LATCH_HI:LATCH_LO], instr.k_jump};

  // Handshake: no new instruction during the second cycle
  assign instr_ready = state_r == ST_RUN;

  // ****************************************************************
  // Next values
  // ****************************************************************
  // Accumulator takes OR literal or a destination-0 result
  assign acc_nxt = !fire ? acc_r :
                   is_orl ? result :
                   (to_dest && instr.dest == DEST_ACC) ? result : acc_r;
  // Carry only from the shift, zero only where affected
  assign carry_nxt = (fire && is_shl) ? file_rdata[SHIFT_OUT_BIT] : carry_r;
  assign zero_nxt = (fire && sets_zero) ? res_is_zero : zero_r;
  assign res_nxt = fire ? result : res_r;
  assign pc_nxt = (fire && is_jump) ? jump_tgt : pc_r;
  // File write when destination is 1, one driver for the whole struct
  assign fwr_nxt = '{en: fire && to_dest && instr.dest == DEST_FILE,
                     addr: instr.faddr,
                     data: result};

  // Sequencer: jump and taken skip insert one bubble cycle
  always_comb begin
    case (state_r)
      ST_RUN: begin
        if (fire && (is_jump || skip_now)) begin
          state_nxt = ST_BUBBLE;
        end else begin
          state_nxt = ST_RUN;
        end
      end
      ST_BUBBLE: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // State and architectural registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_RUN;
      acc_r <= ACC_RST;
      carry_r <= FLAG_RST;
      zero_r <= FLAG_RST;
      res_r <= ACC_RST;
      pc_r <= PC_RST;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
      res_r <= res_nxt;
      pc_r <= pc_nxt;
    end
  end

  // One-cycle strobes and file write
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc_load_r <= 1'b0;
      skip_r <= 1'b0;
      fwr_r <= '0;
    end else begin
      pc_load_r <= fire && is_jump;
      skip_r <= fire && skip_now;
      fwr_r <= fwr_nxt;
    end
  end

  assign acc = acc_r;
  assign carry = carry_r;
  assign zero = zero_r;
  assign pc_load = pc_load_r;
  assign pc_value = pc_r;
  assign skip_taken = skip_r;
  assign fwr = fwr_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_bubble_then_run;
    !instr_ready ##1 instr_ready;
  endsequence

  sequence s_load_pulse;
    pc_load ##1 !pc_load;
  endsequence

  AST_JUMP_TARGET: assert property (fire && is_jump |=> pc_load &&
      pc_value[JUMP_K_W-1:0] == $past(instr.k_jump))
    else $error("jump low target bits wrong");
  AST_JUMP_UPPER: assert property (fire && is_jump |=>
      pc_value[PC_W-1:JUMP_K_W] == $past(pc_high_latch[LATCH_HI:LATCH_LO]))
    else $error("jump upper target bits wrong");
  AST_JUMP_TWO_CYCLE: assert property (fire && is_jump |=> s_bubble_then_run ##0
      (carry == $past(carry, 2) && zero == $past(zero, 2)))
    else $error("jump timing or flags wrong");
  AST_DEST_SELECT: assert property (fire && to_dest |=>
      fwr.en == $past(instr.dest) && (!fwr.en || fwr.addr == $past(instr.faddr)))
    else $error("destination select wrong");
  AST_INCR_SUM: assert property (fire && (is_inc || is_incsz) |=>
      res_r == $past(file_rdata) + 8'h01)
    else $error("increment result wrong");
  AST_SKIP_ZERO: assert property (fire && is_incsz && inc_val == 8'h00 |=>
      skip_taken ##0 s_bubble_then_run)
    else $error("skip not taken on zero");
  AST_SKIP_FLAGS: assert property (fire && is_incsz |=>
      $stable(zero) && $stable(carry))
    else $error("skip instruction changed flags");
  AST_INCR_NO_SKIP: assert property (fire && is_inc |=> !skip_taken && instr_ready)
    else $error("plain increment skipped");
  AST_OR_LIT: assert property (fire && is_orl |=>
      acc == ($past(acc) | $past(instr.k_lit)))
    else $error("literal OR wrong");
  AST_OR_FILE: assert property (fire && is_orf |=>
      res_r == ($past(acc) | $past(file_rdata)))
    else $error("file OR wrong");
  AST_SHIFT_CARRY: assert property (fire && is_shl |=>
      carry == $past(file_rdata[SHIFT_OUT_BIT]))
    else $error("shift carry wrong");
  AST_SHIFT_RESULT: assert property (fire && is_shl |=>
      res_r == {$past(file_rdata[DATA_W-2:0]), 1'b0})
    else $error("shift result wrong");
  AST_ZERO_FLAG: assert property (fire && sets_zero |=> zero == (res_r == 8'h00))
    else $error("zero flag wrong");
  AST_ONE_CYCLE: assert property (fire && sets_zero |=> instr_ready)
    else $error("single-cycle op stalled");

  // ****************************************************************
  // Strobes, holds and the bubble cycle
  // ****************************************************************
  // Jump load and skip strobes last one cycle only
  AST_JUMP_PULSE: assert property (fire && is_jump |=>
      s_load_pulse)
    else $error("jump load strobe not one cycle");
  AST_SKIP_PULSE: assert property (skip_taken |=>
      !skip_taken)
    else $error("skip strobe not one cycle");
  AST_SKIP_NONZERO: assert property (fire && is_incsz && inc_val != 8'h00 |=>
      !skip_taken && instr_ready)
    else $error("skip taken on nonzero result");
  // Increment sum lands at the chosen destination
  AST_INCR_DEST: assert property (fire && (is_inc || is_incsz) |=>
      (fwr.en ? fwr.data : acc) == $past(file_rdata) + 8'h01)
    else $error("increment sum at wrong place");
  AST_ACC_DEST: assert property (fire && to_dest && instr.dest == DEST_ACC |=>
      acc == res_r && !fwr.en)
    else $error("accumulator destination wrong");
  AST_OR_LIT_KEEP: assert property (fire && is_orl |=>
      !fwr.en && $stable(carry))
    else $error("literal OR touched file or carry");
  // Carry moves only on the shift, zero follows the shifted value
  AST_CARRY_HOLD: assert property (fire && !is_shl |=>
      $stable(carry))
    else $error("carry changed outside shift");
  AST_SHIFT_ZERO: assert property (fire && is_shl |=>
      zero == ($past(file_rdata[DATA_W-2:0]) == 7'h00))
    else $error("shift zero flag wrong");
  // Program counter target holds between jumps
  AST_PC_HOLD: assert property (!(fire && is_jump) |=>
      !pc_load && $stable(pc_value))
    else $error("program counter moved without jump");
  AST_BUBBLE_IDLE: assert property (!instr_ready |=>
      !fwr.en && !pc_load && !skip_taken && $stable(acc))
    else $error("instruction taken in bubble cycle");

endmodule

//--- tb/test_jxs_exec.sv
// Purpose: Self-checking bench for the jump, increment, OR and shift unit
// Assumes: Results show just after the taking edge, sampled 1 ns later
// Notes: Flags and accumulator are tracked here to predict each result

`timescale 1ns/1ps

module test_jxs_exec;
  import jxs_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic instr_valid = 1'b0;
  jxs_instr_t instr = '0;
  logic [DATA_W-1:0] file_rdata = 8'h00;
  logic [LATCH_W-1:0] pc_high_latch = 7'h00;
  logic instr_ready, carry, zero, pc_load, skip_taken;
  jxs_fwr_t fwr;
  logic [DATA_W-1:0] acc;
  logic [PC_W-1:0] pc_value;
  logic [7:0] m_acc = 8'h00;
  logic m_c = 1'b0;
  logic m_z = 1'b0;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ****************
  // Clock, unit, timeout
  // ****************
  always #2.5 mclk = ~mclk;

  jxs_exec i_jxs_exec (.mclk(mclk), .srst(srst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .file_rdata(file_rdata), .pc_high_latch(pc_high_latch),
    .fwr(fwr), .acc(acc), .carry(carry), .zero(zero), .pc_load(pc_load),
    .pc_value(pc_value), .skip_taken(skip_taken));

  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic chk_b(input string nm, input logic e, input logic g);
    chk_v(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  // Offer one instruction, let it be taken, sample in the answer cycle
  task automatic issue(input jxs_op_t op, input logic [10:0] kj, input logic [7:0] kl,
    input logic [6:0] fa, input logic d, input logic [7:0] rd);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= '{op: op, k_jump: kj, k_lit: kl, faddr: fa, dest: d};
    file_rdata <= rd;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // Result at the chosen destination, then flags
  task automatic chk_res(input logic d, input logic [6:0] fa, input logic [7:0] r);
    chk_b("fwr_en", d, fwr.en);
    if (d) begin
      chk_v("fwr_addr", 16'(fa), 16'(fwr.addr));
      chk_v("fwr_data", 16'(r), 16'(fwr.data));
    end else begin
      m_acc = r;
    end
    chk_v("acc", 16'(m_acc), 16'(acc));
    chk_b("carry", m_c, carry);
    chk_b("zero", m_z, zero);
  endtask

  task automatic t_shift(input logic [7:0] rd, input logic d, input logic [6:0] fa);
    issue(OP_SHIFT_LEFT_FILE, 11'h000, 8'h00, fa, d, rd);
    m_c = rd[7];
    m_z = (rd[6:0] == 7'h00);
    chk_res(d, fa, {rd[6:0], 1'b0});
  endtask

  task automatic t_jump();
    @(posedge mclk);
    pc_high_latch <= 7'h5a;
    issue(OP_LONG_JUMP, 11'h7ff, 8'h00, 7'h00, 1'b0, 8'h00);
    chk_b("pc_load", 1'b1, pc_load);
    chk_v("pc_value", 16'h5fff, 16'(pc_value));
    chk_b("ready", 1'b0, instr_ready);
    chk_res(1'b0, 7'h00, m_acc);
    @(posedge mclk);
    #1;
    chk_b("pc_load", 1'b0, pc_load);
    chk_b("ready", 1'b1, instr_ready);
  endtask

  task automatic t_or(input logic lit, input logic [7:0] v, input logic d);
    logic [7:0] r;
    r = m_acc | v;
    m_z = (r == 8'h00);
    if (lit) begin
      issue(OP_OR_LITERAL_INTO_ACC, 11'h000, v, 7'h00, 1'b0, 8'h00);
      chk_res(1'b0, 7'h00, r);
    end else begin
      issue(OP_OR_ACC_WITH_FILE, 11'h000, 8'h00, 7'h00, d, v);
      chk_res(d, 7'h00, r);
    end
  endtask

  task automatic t_incr(input logic sk, input logic [7:0] rd, input logic d);
    logic [7:0] r;
    r = rd + 8'h01;
    issue(sk ? OP_INCR_SKIP_IF_ZERO : OP_INCR_FILE, 11'h000, 8'h00, 7'h7f, d, rd);
    if (!sk) begin
      m_z = (r == 8'h00);
    end
    chk_res(d, 7'h7f, r);
    chk_b("skip", sk && r == 8'h00, skip_taken);
    chk_b("ready", !(sk && r == 8'h00), instr_ready);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    #1;
    chk_res(1'b0, 7'h00, 8'h00);
    chk_b("ready", 1'b1, instr_ready);
    chk_b("pc_load", 1'b0, pc_load);
    chk_b("skip", 1'b0, skip_taken);
    t_shift(8'h80, 1'b0, 7'h00);
    t_jump();
    t_or(1'b1, 8'h00, 1'b0);
    t_or(1'b0, 8'h3c, 1'b1);
    t_or(1'b1, 8'ha5, 1'b0);
    t_or(1'b0, 8'h42, 1'b0);
    t_shift(8'h41, 1'b1, 7'h7f);
    t_incr(1'b0, 8'hff, 1'b1);
    t_incr(1'b0, 8'h10, 1'b0);
    t_incr(1'b1, 8'hff, 1'b1);
    t_incr(1'b1, 8'h05, 1'b0);
    end_of_test();
  end
endmodule
